// ---- rtl/dual_watchdog_reset_logic.sv ----
/*
  dual watchdog reset logic: counter array timer with module 4 (compare,
  capture, pwm or array watchdog) and a dedicated 14-bit machine-cycle
  watchdog that pulses the reset pin on overflow.
  assumes: the core drives the special-function register strobes on I_CLK;
  I_MACHINE_CYCLE and I_TIMER_TICK are one-cycle strobes from the same clock;
  I_CAPTURE_PIN is an asynchronous pin; chip reset arrives on I_SRST.
*/
`timescale 1ns/1ps

// Function
// - module 4 alone offers the watchdog, and keeps its compare and capture modes.
// - armed array watchdog raises internal reset when timer equals 16-bit compare value.
// - array watchdog internal reset never drives the reset pin.
// - arming needs module 4 in compare mode and mode bit 40H set.
// - clearing the arm bit blocks match resets; setting again re-enables them.
// - dedicated watchdog holds a 14-bit counter and one service key register.
// - after any reset the dedicated watchdog is off and its counter frozen.
// - writing 01EH then 0E1H to key register 0A6H arms the watchdog.
// - armed counter increments once every machine cycle.
// - software cannot disarm; only hardware or overflow reset does.
// - counter reaching 3FFFH overflows and resets the device.
// - each completed key pair restarts the armed count.
// - key register is write-only; counter is neither readable nor writable.
// - overflow drives a reset pin pulse lasting 98 oscillator periods.
module dual_watchdog_reset_logic (
  input  wire logic       I_CLK,
  input  wire logic       I_SRST,
  input  wire logic       I_CE,
  input  wire logic       I_MACHINE_CYCLE,
  input  wire logic       I_TIMER_TICK,
  input  wire logic       I_CAPTURE_PIN,
  input  wire logic [7:0] I_SFR_ADDR,
  input  wire logic [7:0] I_SFR_WDATA,
  input  wire logic       I_SFR_WE,
  input  wire logic       I_SFR_RE,
  output logic      [7:0] O_SFR_RDATA,
  output logic            O_INTERNAL_RESET,
  output logic            O_RST_PIN_OUT,
  output logic            O_RST_PIN_OE,
  output logic            O_MODULE4_FLAG,
  output logic            O_HSO_OUT,
  output logic            O_PWM_OUT
);

  typedef struct packed {
    wdog_pkg::wd_state_t wd_state;
    logic                key_half;
    logic [13:0]         wd_count;
    logic [7:0]          rst_cnt;
    logic                rst_out;
    logic                int_rst;
    logic [15:0]         timer;
    logic                tick_d;
    logic [7:0]          arr_mode;
    logic [6:0]          m4_mode;
    logic [15:0]         cmp;
    logic                flag;
    logic [7:0]          rdata;
    logic                pin_s0;
    logic                pin_s1;
  } top_state_t;

  localparam top_state_t TOP_RST = '{
    wd_state: wdog_pkg::WD_OFF,
    key_half: 1'b0,
    wd_count: wdog_pkg::WD_COUNT_RST,
    rst_cnt:  8'h00,
    rst_out:  1'b0,
    int_rst:  1'b0,
    timer:    wdog_pkg::TIMER_RST,
    tick_d:   1'b0,
    arr_mode: wdog_pkg::ARRAY_MODE_RST,
    m4_mode:  wdog_pkg::MODULE4_MODE_RST,
    cmp:      wdog_pkg::CMP_RST,
    flag:     1'b0,
    rdata:    wdog_pkg::RDATA_RST,
    pin_s0:   1'b0,
    pin_s1:   1'b0
  };

  top_state_t  st_ff;
  top_state_t  nxt_st;

  logic        m4_match;
  logic        m4_cap_load;
  logic [15:0] m4_cap_val;
  logic        m4_hso;
  logic        m4_pwm;
  logic        m4_pwm_reload;

  logic        key_wr;
  logic        key_restart;
  logic        arr_armed;
  logic        wd_overflow;

  module4_compare_unit u_module4 (
    .i_clk        (I_CLK),
    .i_srst       (I_SRST),
    .i_ce         (I_CE),
    .i_mode       (st_ff.m4_mode),
    .i_cmp        (st_ff.cmp),
    .i_timer      (st_ff.timer),
    .i_eval       (st_ff.tick_d),
    .i_pin        (st_ff.pin_s1),
    .o_match      (m4_match),
    .o_cap_load   (m4_cap_load),
    .o_cap_val    (m4_cap_val),
    .o_hso        (m4_hso),
    .o_pwm        (m4_pwm),
    .o_pwm_reload (m4_pwm_reload)
  );

  assign key_wr      = I_SFR_WE && (I_SFR_ADDR == wdog_pkg::ADDR_SERVICE_KEY);
  assign key_restart = key_wr && st_ff.key_half && (I_SFR_WDATA == wdog_pkg::KEY_SECOND);
  assign arr_armed   = |(st_ff.arr_mode & wdog_pkg::ARRAY_WDOG_ARM_MASK);
  assign wd_overflow = (st_ff.wd_state == wdog_pkg::WD_ON) && !key_restart &&
                       I_MACHINE_CYCLE && (st_ff.wd_count == wdog_pkg::WD_TOP - 14'h0001);

  always_comb begin
    nxt_st = st_ff;
    if (I_CE) begin
      nxt_st.pin_s0  = I_CAPTURE_PIN;
      nxt_st.pin_s1  = st_ff.pin_s0;
      nxt_st.tick_d  = I_TIMER_TICK;
      nxt_st.int_rst = 1'b0;

      if (I_TIMER_TICK) begin
        nxt_st.timer = st_ff.timer + 16'h0001;
      end
      if (m4_cap_load) begin
        nxt_st.cmp = m4_cap_val;
      end
      if (m4_pwm_reload) begin
        nxt_st.cmp[7:0] = st_ff.cmp[15:8];
      end

      // a software write to the timer or compare wins over hardware updates
      if (I_SFR_WE) begin
        if (I_SFR_ADDR == wdog_pkg::ADDR_ARRAY_MODE) begin
          nxt_st.arr_mode = I_SFR_WDATA;
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_MODULE4_MODE) begin
          nxt_st.m4_mode = I_SFR_WDATA[6:0];
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_CMP_LOW) begin
          nxt_st.cmp[7:0] = I_SFR_WDATA;
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_CMP_HIGH) begin
          nxt_st.cmp[15:8] = I_SFR_WDATA;
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_TIMER_LOW) begin
          nxt_st.timer[7:0] = I_SFR_WDATA;
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_TIMER_HIGH) begin
          nxt_st.timer[15:8] = I_SFR_WDATA;
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_MODULE4_FLAG) begin
          if (!I_SFR_WDATA[0]) begin
            nxt_st.flag = 1'b0;
          end
        end
      end
      // set after the clear so a same-cycle event is kept
      if (m4_match || m4_cap_load) begin
        nxt_st.flag = 1'b1;
      end

      // array watchdog: internal reset only, the pin stays untouched
      if (m4_match && arr_armed && wdog_pkg::mode_is_watchdog(st_ff.m4_mode)) begin
        nxt_st.int_rst = 1'b1;
      end

      if (key_wr) begin
        nxt_st.key_half = (I_SFR_WDATA == wdog_pkg::KEY_FIRST);
      end

      if (st_ff.rst_out) begin
        if (st_ff.rst_cnt == 8'h01) begin
          nxt_st.rst_out = 1'b0;
          nxt_st.rst_cnt = 8'h00;
        end else begin
          nxt_st.rst_cnt = st_ff.rst_cnt - 8'h01;
        end
      end

      case (st_ff.wd_state)
        wdog_pkg::WD_OFF: begin
          nxt_st.wd_count = wdog_pkg::WD_COUNT_RST;
          if (key_restart) begin
            nxt_st.wd_state = wdog_pkg::WD_ON;
          end
        end
        wdog_pkg::WD_ON: begin
          // no path back to off except overflow or chip reset
          if (key_restart) begin
            nxt_st.wd_count = wdog_pkg::WD_COUNT_RST;
          end else if (wd_overflow) begin
            nxt_st.wd_state = wdog_pkg::WD_OFF;
            nxt_st.wd_count = wdog_pkg::WD_COUNT_RST;
            nxt_st.rst_out  = 1'b1;
            nxt_st.rst_cnt  = wdog_pkg::RST_PULSE_CYCLES;
          end else if (I_MACHINE_CYCLE) begin
            nxt_st.wd_count = st_ff.wd_count + 14'h0001;
          end
        end
        default: begin
          nxt_st.wd_state = wdog_pkg::WD_OFF;
        end
      endcase

      // the key register and the watchdog counter read back as zero
      if (I_SFR_RE) begin
        if (I_SFR_ADDR == wdog_pkg::ADDR_ARRAY_MODE) begin
          nxt_st.rdata = st_ff.arr_mode;
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_MODULE4_MODE) begin
          nxt_st.rdata = {1'b0, st_ff.m4_mode};
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_CMP_LOW) begin
          nxt_st.rdata = st_ff.cmp[7:0];
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_CMP_HIGH) begin
          nxt_st.rdata = st_ff.cmp[15:8];
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_TIMER_LOW) begin
          nxt_st.rdata = st_ff.timer[7:0];
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_TIMER_HIGH) begin
          nxt_st.rdata = st_ff.timer[15:8];
        end else if (I_SFR_ADDR == wdog_pkg::ADDR_MODULE4_FLAG) begin
          nxt_st.rdata = {7'h00, st_ff.flag};
        end else begin
          nxt_st.rdata = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      st_ff <= TOP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign O_SFR_RDATA      = st_ff.rdata;
  assign O_INTERNAL_RESET = st_ff.int_rst;
  assign O_RST_PIN_OUT    = st_ff.rst_out;
  assign O_RST_PIN_OE     = st_ff.rst_out;
  assign O_MODULE4_FLAG   = st_ff.flag;
  assign O_HSO_OUT        = m4_hso;
  assign O_PWM_OUT        = m4_pwm;

  // helper: running length of the current reset pin pulse, in enabled cycles, cleared one enabled cycle after the pin falls
  logic [7:0] pulse_len_ff;
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      pulse_len_ff <= 8'h00;
    end else if (I_CE) begin
      if (!st_ff.rst_out) begin
        pulse_len_ff <= 8'h00;
      end else begin
        pulse_len_ff <= pulse_len_ff + 8'h01;
      end
    end
  end

  sequence s_first_key;
    I_CE && key_wr && (I_SFR_WDATA == wdog_pkg::KEY_FIRST);
  endsequence

  sequence s_second_key;
    I_CE && key_restart;
  endsequence

  property p_arm_pair;
    @(posedge I_CLK) disable iff (I_SRST)
      s_second_key |=> (st_ff.wd_state == wdog_pkg::WD_ON) && (st_ff.wd_count == 14'h0000);
  endproperty
  a_arm_pair: assert property (p_arm_pair) else $error("key pair did not arm");

  property p_abandon;
    @(posedge I_CLK) disable iff (I_SRST)
      s_first_key ##1 (I_CE && key_wr && (I_SFR_WDATA != wdog_pkg::KEY_SECOND)
                       && (I_SFR_WDATA != wdog_pkg::KEY_FIRST)) |=> !st_ff.key_half;
  endproperty
  a_abandon: assert property (p_abandon) else $error("bad second key kept");

  property p_off_frozen;
    @(posedge I_CLK) disable iff (I_SRST)
      (st_ff.wd_state == wdog_pkg::WD_OFF) && !key_restart |=> (st_ff.wd_count == 14'h0000);
  endproperty
  a_off_frozen: assert property (p_off_frozen) else $error("idle watchdog counts");

  property p_count_step;
    @(posedge I_CLK) disable iff (I_SRST)
      I_CE && (st_ff.wd_state == wdog_pkg::WD_ON) && I_MACHINE_CYCLE && !key_restart
      && !wd_overflow |=> (st_ff.wd_count == $past(st_ff.wd_count) + 14'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_no_disarm;
    @(posedge I_CLK) disable iff (I_SRST)
      (st_ff.wd_state == wdog_pkg::WD_ON) && !(I_CE && wd_overflow)
      |=> (st_ff.wd_state == wdog_pkg::WD_ON);
  endproperty
  a_no_disarm: assert property (p_no_disarm) else $error("watchdog left on state");

  property p_overflow_pulse;
    @(posedge I_CLK) disable iff (I_SRST)
      I_CE && wd_overflow |=> O_RST_PIN_OUT && O_RST_PIN_OE
      && (st_ff.wd_state == wdog_pkg::WD_OFF);
  endproperty
  a_overflow_pulse: assert property (p_overflow_pulse) else $error("no reset pulse");

  property p_pulse_len;
    @(posedge I_CLK) disable iff (I_SRST)
      $fell(O_RST_PIN_OUT) |-> (pulse_len_ff == wdog_pkg::RST_PULSE_CYCLES);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse width wrong");

  property p_pin_source;
    @(posedge I_CLK) disable iff (I_SRST)
      $rose(O_RST_PIN_OUT) |-> $past(I_CE && wd_overflow);
  endproperty
  a_pin_source: assert property (p_pin_source) else $error("pin driven without overflow");

  property p_match_reset;
    @(posedge I_CLK) disable iff (I_SRST)
      I_CE && m4_match && wdog_pkg::mode_is_watchdog(st_ff.m4_mode)
      |=> (O_INTERNAL_RESET == $past(arr_armed));
  endproperty
  a_match_reset: assert property (p_match_reset) else $error("match reset wrong");

  property p_key_reads_zero;
    @(posedge I_CLK) disable iff (I_SRST)
      I_CE && I_SFR_RE && (I_SFR_ADDR == wdog_pkg::ADDR_SERVICE_KEY) |=> (O_SFR_RDATA == 8'h00);
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key reg readable");

endmodule

// ---- rtl/module4_compare_unit.sv ----
/*
  compare/capture unit of counter array module 4: software timer, high speed
  output, positive/negative edge capture and 8-bit pwm.
  assumes: i_pin already synchronised; i_eval pulses the cycle after the
  array timer has advanced; the owner writes back captured values.
*/
`timescale 1ns/1ps

module module4_compare_unit (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic [6:0]  i_mode,
  input  wire logic [15:0] i_cmp,
  input  wire logic [15:0] i_timer,
  input  wire logic        i_eval,
  input  wire logic        i_pin,
  output logic             o_match,
  output logic             o_cap_load,
  output logic [15:0]      o_cap_val,
  output logic             o_hso,
  output logic             o_pwm,
  output logic             o_pwm_reload
);

  typedef struct packed {
    logic        pin_prev;
    logic        match;
    logic        cap_load;
    logic [15:0] cap_val;
    logic        hso;
    logic        pwm;
    logic        pwm_reload;
  } unit_state_t;

  localparam unit_state_t UNIT_RST = '0;

  unit_state_t st_ff;
  unit_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_ce) begin
      nxt_st.pin_prev   = i_pin;
      nxt_st.match      = 1'b0;
      nxt_st.cap_load   = 1'b0;
      nxt_st.pwm_reload = 1'b0;
      // compare only once per timer step so a stalled timer cannot re-fire
      if (i_mode[wdog_pkg::M_ECOM] && i_mode[wdog_pkg::M_MAT] && !i_mode[wdog_pkg::M_PWM]
          && i_eval && (i_timer == i_cmp)) begin
        nxt_st.match = 1'b1;
        if (i_mode[wdog_pkg::M_TOG]) begin
          nxt_st.hso = ~st_ff.hso;
        end
      end
      if ((i_mode[wdog_pkg::M_CAPP] && i_pin && !st_ff.pin_prev) ||
          (i_mode[wdog_pkg::M_CAPN] && !i_pin && st_ff.pin_prev)) begin
        nxt_st.cap_load = 1'b1;
        nxt_st.cap_val  = i_timer;
      end
      if (i_mode[wdog_pkg::M_ECOM] && i_mode[wdog_pkg::M_PWM]) begin
        nxt_st.pwm = (i_timer[7:0] >= i_cmp[7:0]);
        if (i_eval && (i_timer[7:0] == 8'h00)) begin
          nxt_st.pwm_reload = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_ff <= UNIT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_match      = st_ff.match;
  assign o_cap_load   = st_ff.cap_load;
  assign o_cap_val    = st_ff.cap_val;
  assign o_hso        = st_ff.hso;
  assign o_pwm        = st_ff.pwm;
  assign o_pwm_reload = st_ff.pwm_reload;

  property p_capture_rise;
    @(posedge i_clk) disable iff (i_srst)
      (i_ce && i_mode[wdog_pkg::M_CAPP] && i_pin && !st_ff.pin_prev)
      |=> (o_cap_load && (o_cap_val == $past(i_timer)));
  endproperty
  a_capture_rise: assert property (p_capture_rise) else $error("capture missed");

endmodule

// ---- rtl/wdog_pkg.sv ----
/*
  constants, types and helpers shared by the dual watchdog block and its
  module 4 compare unit.
  assumes: core clock at 125 MHz, which also serves as the oscillator period
  for the reset pulse width; the special-function register bus is 8 bits wide.
*/
package wdog_pkg;

  // special-function register addresses
  localparam logic [7:0] ADDR_SERVICE_KEY  = 8'hA6;
  localparam logic [7:0] ADDR_ARRAY_MODE   = 8'hC1;
  localparam logic [7:0] ADDR_MODULE4_MODE = 8'hC2;
  localparam logic [7:0] ADDR_CMP_LOW      = 8'hC3;
  localparam logic [7:0] ADDR_CMP_HIGH     = 8'hC4;
  localparam logic [7:0] ADDR_TIMER_LOW    = 8'hC5;
  localparam logic [7:0] ADDR_TIMER_HIGH   = 8'hC6;
  localparam logic [7:0] ADDR_MODULE4_FLAG = 8'hC7;

  // array mode register: watchdog arm bit
  localparam logic [7:0] ARRAY_WDOG_ARM_MASK = 8'h40;

  // module 4 mode register field positions
  localparam int M_ECOM = 6;
  localparam int M_CAPP = 5;
  localparam int M_CAPN = 4;
  localparam int M_MAT  = 3;
  localparam int M_TOG  = 2;
  localparam int M_PWM  = 1;
  localparam int M_ECCF = 0;

  // values after reset
  localparam logic [7:0]  ARRAY_MODE_RST   = 8'h00;
  localparam logic [6:0]  MODULE4_MODE_RST = 7'h00;
  localparam logic [15:0] CMP_RST          = 16'h0000;
  localparam logic [15:0] TIMER_RST        = 16'h0000;
  localparam logic [13:0] WD_COUNT_RST     = 14'h0000;
  localparam logic [7:0]  RDATA_RST        = 8'h00;

  // dedicated watchdog key pair and terminal count
  localparam logic [7:0]  KEY_FIRST  = 8'h1E;
  localparam logic [7:0]  KEY_SECOND = 8'hE1;
  localparam logic [13:0] WD_TOP     = 14'h3FFF;

  // reset pulse: 98 oscillator periods
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int T_OSC_PS         = 8000;
  localparam int RST_PULSE_PERIODS = 98;
  localparam int RST_PULSE_PS     = RST_PULSE_PERIODS * T_OSC_PS;
  localparam logic [7:0] RST_PULSE_CYCLES =
    8'((RST_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic {WD_OFF, WD_ON} wd_state_t;

  // module 4 set up as a compare unit that may act as array watchdog
  function automatic logic mode_is_watchdog(input logic [6:0] m);
    return m[M_ECOM] & m[M_MAT] & ~m[M_CAPP] & ~m[M_CAPN] & ~m[M_PWM];
  endfunction

endpackage

// ---- verif/tb.sv ----
/*
  self-checking bench for the dual watchdog reset logic: register reads and
  writes, the module 4 array watchdog and the dedicated key-armed watchdog.
  assumes: the design answers reads on the taking edge itself and
  drives the reset pin for 98 core cycles on dedicated watchdog overflow.
*/
`timescale 1ns/1ps

module tb;
  localparam int TIMEOUT_CYCLES = 95000;
  localparam int WD_SPAN        = 16383;

  logic       clk;
  logic       srst;
  logic       mc;
  logic       tick;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic       re;
  logic [7:0] rdata;
  logic       int_rst;
  logic       pin_out;
  logic       pin_oe;
  logic       flag;
  logic       ce;
  logic       cap_pin;
  logic       hso;
  logic       pwm;
  int         n_fail;
  int         n_checks;
  int         cyc;
  int         pin_hi;
  int         int_hi;
  int         oe_bad;
  int         p0;
  int         i0;

  dual_watchdog_reset_logic DUT (
    .I_CLK            (clk),
    .I_SRST           (srst),
    .I_CE             (ce),
    .I_MACHINE_CYCLE  (mc),
    .I_TIMER_TICK     (tick),
    .I_CAPTURE_PIN    (cap_pin),
    .I_SFR_ADDR       (addr),
    .I_SFR_WDATA      (wdata),
    .I_SFR_WE         (we),
    .I_SFR_RE         (re),
    .O_SFR_RDATA      (rdata),
    .O_INTERNAL_RESET (int_rst),
    .O_RST_PIN_OUT    (pin_out),
    .O_RST_PIN_OE     (pin_oe),
    .O_MODULE4_FLAG   (flag),
    .O_HSO_OUT        (hso),
    .O_PWM_OUT        (pwm)
  );

  always #4 clk = ~clk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // sampled on the rising edge so the counts never race the test procedure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pin_out === 1'b1) pin_hi <= pin_hi + 1;
    if (int_rst === 1'b1) int_hi <= int_hi + 1;
    if (pin_oe !== pin_out) oe_bad <= oe_bad + 1;
    if (cyc == TIMEOUT_CYCLES) begin
      n_fail = n_fail + 1;
      $display("MISMATCH timeout expected finish seen hang");
      give_verdict();
    end
  end

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_count(input string name, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // strobe is dropped and a full cycle passes so back-to-back calls stay clean
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    @(negedge clk);
  endtask

  // two writes on consecutive edges with the strobe held up between them
  task automatic wr2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    addr = a;
    wdata = d0;
    we = 1'b1;
    @(negedge clk);
    wdata = d1;
    @(negedge clk);
    we = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    chk_byte("read data", exp, rdata);
    @(negedge clk);
  endtask

  task automatic run_mc(input int n);
    mc = 1'b1;
    repeat (n) @(negedge clk);
    mc = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic arr_case(input logic [7:0] mode, input logic [7:0] arm,
                          input logic [7:0] cmp_hi, input int exp_int,
                          input logic exp_flag, input logic exp_hso);
    wr(wdog_pkg::ADDR_MODULE4_MODE, mode);
    wr(wdog_pkg::ADDR_CMP_LOW, 8'h05);
    wr(wdog_pkg::ADDR_CMP_HIGH, cmp_hi);
    wr(wdog_pkg::ADDR_TIMER_LOW, 8'h04);
    wr(wdog_pkg::ADDR_TIMER_HIGH, 8'h00);
    wr(wdog_pkg::ADDR_ARRAY_MODE, arm);
    i0 = int_hi;
    p0 = pin_hi;
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (8) @(negedge clk);
    chk_count("internal reset cycles", exp_int, int_hi - i0);
    chk_count("reset pin cycles", 0, pin_hi - p0);
    chk_byte("module4 flag", {7'h00, exp_flag}, {7'h00, flag});
    chk_byte("compare output", {7'h00, exp_hso}, {7'h00, hso});
    wr(wdog_pkg::ADDR_MODULE4_FLAG, 8'h00);
    $display("test array watchdog mode %h arm %h done", mode, arm);
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    mc = 1'b0;
    tick = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    we = 1'b0;
    re = 1'b0;
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    pin_hi = 0;
    int_hi = 0;
    oe_bad = 0;
    ce = 1'b1;
    cap_pin = 1'b0;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);

    rd_chk(wdog_pkg::ADDR_ARRAY_MODE, 8'h00);
    rd_chk(wdog_pkg::ADDR_CMP_LOW, 8'h00);
    rd_chk(wdog_pkg::ADDR_CMP_HIGH, 8'h00);
    wr(8'h80, 8'h5A);
    rd_chk(8'h80, 8'h00);
    wr(wdog_pkg::ADDR_ARRAY_MODE, wdog_pkg::ARRAY_WDOG_ARM_MASK);
    rd_chk(wdog_pkg::ADDR_ARRAY_MODE, 8'h40);
    // with the enable low a write must not land
    ce = 1'b0;
    wr(wdog_pkg::ADDR_ARRAY_MODE, 8'h00);
    ce = 1'b1;
    rd_chk(wdog_pkg::ADDR_ARRAY_MODE, 8'h40);
    $display("test registers done");

    arr_case(8'h4C, 8'h40, 8'h00, 1, 1'b1, 1'b1);
    arr_case(8'h4C, 8'h00, 8'h00, 0, 1'b1, 1'b0);
    arr_case(8'h4C, 8'h40, 8'h00, 1, 1'b1, 1'b1);
    arr_case(8'h48, 8'h40, 8'h00, 1, 1'b1, 1'b1);
    arr_case(8'h4C, 8'h40, 8'h01, 0, 1'b0, 1'b1);
    arr_case(8'h20, 8'h40, 8'h00, 0, 1'b0, 1'b1);

    // capture: a rising pin edge loads the running timer into the compare pair
    wr(wdog_pkg::ADDR_TIMER_LOW, 8'h3C);
    cap_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk_byte("module4 flag", 8'h01, {7'h00, flag});
    rd_chk(wdog_pkg::ADDR_CMP_LOW, 8'h3C);
    wr(wdog_pkg::ADDR_MODULE4_MODE, 8'h42);
    wr(wdog_pkg::ADDR_CMP_LOW, 8'h80);
    wr(wdog_pkg::ADDR_TIMER_LOW, 8'h90);
    chk_byte("pwm output", 8'h01, {7'h00, pwm});
    wr(wdog_pkg::ADDR_TIMER_LOW, 8'h10);
    chk_byte("pwm output", 8'h00, {7'h00, pwm});
    $display("test capture and pwm done");

    // a mid-run reset must disarm, and a broken key pair after it must not arm
    wr(wdog_pkg::ADDR_SERVICE_KEY, wdog_pkg::KEY_FIRST);
    wr(wdog_pkg::ADDR_SERVICE_KEY, wdog_pkg::KEY_SECOND);
    run_mc(40);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    wr2(wdog_pkg::ADDR_SERVICE_KEY, wdog_pkg::KEY_FIRST, 8'h55);
    wr(wdog_pkg::ADDR_SERVICE_KEY, wdog_pkg::KEY_SECOND);
    p0 = pin_hi;
    run_mc(WD_SPAN + 17);
    chk_count("reset pin cycles", 0, pin_hi - p0);
    $display("test dedicated idle done");

    wr(wdog_pkg::ADDR_SERVICE_KEY, wdog_pkg::KEY_FIRST);
    wr(wdog_pkg::ADDR_SERVICE_KEY, wdog_pkg::KEY_SECOND);
    wr(wdog_pkg::ADDR_SERVICE_KEY, 8'h00);
    p0 = pin_hi;
    i0 = int_hi;
    run_mc(WD_SPAN - 1);
    chk_count("reset pin cycles", 0, pin_hi - p0);
    run_mc(1);
    repeat (120) @(negedge clk);
    chk_count("reset pin cycles", 98, pin_hi - p0);
    chk_count("pin enable mismatches", 0, oe_bad);
    chk_count("internal reset cycles", 0, int_hi - i0);
    rd_chk(wdog_pkg::ADDR_SERVICE_KEY, 8'h00);
    $display("test dedicated overflow done");

    p0 = pin_hi;
    run_mc(WD_SPAN + 17);
    chk_count("reset pin cycles", 0, pin_hi - p0);
    $display("test dedicated off after overflow done");

    wr(wdog_pkg::ADDR_SERVICE_KEY, wdog_pkg::KEY_FIRST);
    wr(wdog_pkg::ADDR_SERVICE_KEY, wdog_pkg::KEY_SECOND);
    run_mc(WD_SPAN - 1);
    wr(wdog_pkg::ADDR_SERVICE_KEY, wdog_pkg::KEY_FIRST);
    wr(wdog_pkg::ADDR_SERVICE_KEY, wdog_pkg::KEY_SECOND);
    p0 = pin_hi;
    run_mc(WD_SPAN - 1);
    chk_count("reset pin cycles", 0, pin_hi - p0);
    run_mc(1);
    repeat (120) @(negedge clk);
    chk_count("reset pin cycles", 98, pin_hi - p0);
    $display("test dedicated service done");

    give_verdict();
  end
endmodule
